// *** verilog/vector_unit.sv ***
`timescale 1ns/10ps
module vector_unit
   import vector_pkg::*;
(
   input  wire logic              SYS_CLK_I,
   input  wire logic              RSTN_I,
   input  wire logic              BOOT_RESET_FUSE_I,
   input  wire logic [ADDR_W-1:0] BOOT_START_I,
   input  vector_pkg::irq_lines_t IRQ_I,
   input  vector_pkg::irq_lines_t IRQ_EN_I,
   input  wire logic              GLOBAL_IE_I,
   input  wire logic              TAKE_OK_I,
   input  wire logic              INSTR_DONE_I,
   input  wire logic              CTRL_WR_I,
   input  wire logic [1:0]        CTRL_WDATA_I,
   output logic                   RESET_FETCH_O,
   output logic [ADDR_W-1:0]      RESET_ADDR_O,
   output logic                   FETCH_VALID_O,
   output logic [ADDR_W-1:0]      FETCH_ADDR_O,
   output logic [SRC_N-1:0]       FETCH_ACK_O,
   output logic                   VECTOR_BASE_SELECT_O,
   output logic                   VECTOR_CHANGE_UNLOCK_O,
   output logic                   DISPATCH_BLOCKED_O
);
   import vector_pkg::*;

   // ----------------------------------------------------------------------
   // Reset release and pin synchronisers
   // ----------------------------------------------------------------------
   logic              rst_meta;
   logic              rst_n;
   logic              fuse_meta;
   logic              fuse_sync;
   logic [ADDR_W-1:0] boot_meta;
   logic [ADDR_W-1:0] boot_sync;

   always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // Fuse levels are static, so a plain two-stage sync is enough for the bus
   always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         fuse_meta <= FUSE_UNPROG;
         fuse_sync <= FUSE_UNPROG;
         boot_meta <= '0;
         boot_sync <= '0;
      end else begin
         fuse_meta <= BOOT_RESET_FUSE_I;
         fuse_sync <= fuse_meta;
         boot_meta <= BOOT_START_I;
         boot_sync <= boot_meta;
      end
   end

   // ----------------------------------------------------------------------
   // Reset fetch: waits for the synchronisers, then issues one pulse
   // ----------------------------------------------------------------------
   logic [1:0]        boot_cnt;
   logic [1:0]        next_boot_cnt;
   logic              booted;
   logic              next_booted;
   logic              reset_fetch;
   logic              next_reset_fetch;
   logic [ADDR_W-1:0] reset_addr;
   logic [ADDR_W-1:0] next_reset_addr;

   always_comb begin
      next_boot_cnt    = boot_cnt;
      next_booted      = booted;
      next_reset_fetch = 1'b0;
      next_reset_addr  = reset_addr;
      if (!booted) begin
         if (boot_cnt == BOOT_WAIT) begin
            next_booted      = 1'b1;
            next_reset_fetch = 1'b1;
            // Fuse is caught once here so a later pin glitch cannot move reset
            if (fuse_sync == FUSE_UNPROG) begin
               next_reset_addr = RESET_ADDR_APP;
            end else begin
               next_reset_addr = boot_sync;
            end
         end else begin
            next_boot_cnt = boot_cnt + 2'h1;
         end
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         boot_cnt    <= '0;
         booted      <= 1'b0;
         reset_fetch <= 1'b0;
         reset_addr  <= RESET_ADDR_APP;
      end else begin
         boot_cnt    <= next_boot_cnt;
         booted      <= next_booted;
         reset_fetch <= next_reset_fetch;
         reset_addr  <= next_reset_addr;
      end
   end

   // ----------------------------------------------------------------------
   // Vector base select with timed unlock
   // ----------------------------------------------------------------------
   logic       sel;
   logic       next_sel;
   logic       unlock;
   logic       next_unlock;
   logic [2:0] unlock_cnt;
   logic [2:0] next_unlock_cnt;
   logic       post_write;
   logic       next_post_write;
   logic       wr_unlock;
   logic       wr_select;

   always_comb begin
      wr_unlock       = CTRL_WR_I && CTRL_WDATA_I[CTRL_UNLOCK_BIT];
      wr_select       = CTRL_WR_I && !CTRL_WDATA_I[CTRL_UNLOCK_BIT] && unlock;
      next_sel        = sel;
      next_unlock     = unlock;
      next_unlock_cnt = unlock_cnt;
      next_post_write = post_write;
      if (post_write && INSTR_DONE_I) begin
         next_post_write = 1'b0;
      end
      if (wr_unlock) begin
         // A second unlock write restarts the window
         next_unlock     = 1'b1;
         next_unlock_cnt = UNLOCK_LOAD;
      end else if (wr_select) begin
         next_sel        = CTRL_WDATA_I[CTRL_SELECT_BIT];
         next_unlock     = 1'b0;
         next_unlock_cnt = '0;
         next_post_write = 1'b1;
      end else if (unlock) begin
         next_unlock_cnt = unlock_cnt - 3'h1;
         if (unlock_cnt == 3'h1) begin
            next_unlock = 1'b0;
         end
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         sel        <= 1'b0;
         unlock     <= 1'b0;
         unlock_cnt <= '0;
         post_write <= 1'b0;
      end else begin
         sel        <= next_sel;
         unlock     <= next_unlock;
         unlock_cnt <= next_unlock_cnt;
         post_write <= next_post_write;
      end
   end

   // ----------------------------------------------------------------------
   // Dispatch
   // ----------------------------------------------------------------------
   logic [SRC_N-1:0]  live;
   logic              any_live;
   logic [IDX_W-1:0]  pick;
   logic              blocked;
   logic [ADDR_W-1:0] vec_base;
   fetch_t            fetch;
   fetch_t            next_fetch;

   assign live = IRQ_I & IRQ_EN_I;

   pending_pick u_pick (
      .pending_i (live),
      .any_o     (any_live),
      .index_o   (pick)
   );

   always_comb begin
      // Unlock set this cycle already blocks; the global enable is left alone
      blocked    = unlock || post_write || wr_unlock;
      vec_base   = sel ? boot_sync : RESET_ADDR_APP;
      next_fetch = '0;
      if (booted && GLOBAL_IE_I && TAKE_OK_I && any_live && !blocked) begin
         next_fetch.valid     = 1'b1;
         next_fetch.addr      = vec_base + VEC_OFFSET[pick];
         next_fetch.ack[pick] = 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         fetch <= '0;
      end else begin
         fetch <= next_fetch;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs, all from flip-flops
   // ----------------------------------------------------------------------
   logic blocked_q;

   always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         blocked_q <= 1'b0;
      end else begin
         blocked_q <= next_unlock || next_post_write;
      end
   end

   assign RESET_FETCH_O          = reset_fetch;
   assign RESET_ADDR_O           = reset_addr;
   assign FETCH_VALID_O          = fetch.valid;
   assign FETCH_ADDR_O           = fetch.addr;
   assign FETCH_ACK_O            = fetch.ack;
   assign VECTOR_BASE_SELECT_O   = sel;
   assign VECTOR_CHANGE_UNLOCK_O = unlock;
   assign DISPATCH_BLOCKED_O     = blocked_q;

endmodule : vector_unit

// *** verilog/vector_pkg.sv ***
// How it works
// - After any chip reset the fetch address is program word 0 unless boot relocation applies.
// - External requests a, b and c sit at vector offsets 1, 2 and 13 from the vector base.
// - Wide counter capture, match a, match b, overflow use 3..6, narrow overflow 7, match 14.
// - SPI done sits at 8; serial receive, buffer empty and transmit done at 9, 10 and 11.
// - Comparator sits at 12, eeprom write done at 15 and program store done at 16.
// - With the boot reset fuse programmed, reset fetch goes to the boot loader start address.
// - With vector base select set, every vector is its table offset plus the boot start address.
// - Reset address is 0 for fuse 1 else boot start; vector base is 0 or boot start by select.
// - A boot reset fuse level of 1 means unprogrammed and 0 means programmed.
// - A vector is fetched only when an enabled request is taken with global enable set.
// - The unlock bit clears itself four cycles after being set, or when select is written.
// - Dispatch is blocked from unlock set until after the instruction after the select write.
package vector_pkg;

   // ----------------------------------------------------------------------
   // Widths and timing
   // ----------------------------------------------------------------------
   localparam int         ADDR_W        = 12;
   localparam int         SRC_N         = 16;
   localparam int         IDX_W         = 4;
   localparam int         UNLOCK_CYCLES = 4;
   localparam logic [2:0] UNLOCK_LOAD   = 3'h4;
   localparam logic [1:0] BOOT_WAIT     = 2'h3;

   // ----------------------------------------------------------------------
   // Addresses and fuse levels
   // ----------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] RESET_ADDR_APP = 12'h000;
   localparam logic              FUSE_UNPROG    = 1'b1;

   // Vector offsets from the vector base, indexed by source number
   localparam logic [ADDR_W-1:0] VEC_OFFSET [SRC_N] = '{
      12'h001, 12'h002, 12'h003, 12'h004, 12'h005, 12'h006, 12'h007, 12'h008,
      12'h009, 12'h00A, 12'h00B, 12'h00C, 12'h00D, 12'h00E, 12'h00F, 12'h010};

   // ----------------------------------------------------------------------
   // Control write fields
   // ----------------------------------------------------------------------
   localparam int CTRL_UNLOCK_BIT = 0;
   localparam int CTRL_SELECT_BIT = 1;

   // ----------------------------------------------------------------------
   // Request lines, bit 0 is the lowest vector number
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic program_store_done;
      logic eeprom_write_done;
      logic narrow_counter_match;
      logic ext_request_c;
      logic comparator_event;
      logic serial_transmit_done;
      logic serial_tx_buffer_empty;
      logic serial_receive_done;
      logic spi_transfer_done;
      logic narrow_counter_overflow;
      logic wide_counter_overflow;
      logic wide_counter_match_b;
      logic wide_counter_match_a;
      logic wide_counter_capture;
      logic ext_request_b;
      logic ext_request_a;
   } irq_lines_t;

   typedef struct packed {
      logic              valid;
      logic [ADDR_W-1:0] addr;
      logic [SRC_N-1:0]  ack;
   } fetch_t;

endpackage : vector_pkg

// *** verilog/pending_pick.sv ***
`timescale 1ns/10ps
module pending_pick
   import vector_pkg::*;
(
   input  wire logic [SRC_N-1:0] pending_i,
   output logic                  any_o,
   output logic [IDX_W-1:0]      index_o
);

   // ----------------------------------------------------------------------
   // Lowest set bit wins
   // ----------------------------------------------------------------------
   function automatic logic [IDX_W-1:0] lowest(input logic [SRC_N-1:0] v);
      logic [IDX_W-1:0] r;
      r = '0;
      for (int i = SRC_N - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = IDX_W'(i);
         end
      end
      return r;
   endfunction : lowest

   always_comb begin
      any_o   = |pending_i;
      index_o = lowest(pending_i);
   end

endmodule : pending_pick

// *** bench/core_model.sv ***
`timescale 1ns/10ps
module core_model (
   input  wire logic clk_i,
   input  wire logic rstn_i,
   input  wire logic slow_i,
   input  wire logic run_i,
   input  wire logic fetch_i,
   output logic      take_ok_o,
   output logic      done_o
);
   logic [1:0] hold;

   // Refuses at once in the fetch cycle, or a repeat dispatch would slip in
   assign take_ok_o = !fetch_i && hold == 2'h0;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         hold   <= 2'h0;
         done_o <= 1'b0;
      end else begin
         hold   <= fetch_i ? (slow_i ? 2'h3 : 2'h1) : (hold != 2'h0 ? hold - 2'h1 : hold);
         done_o <= run_i && !done_o;
      end
   end
endmodule : core_model

// *** bench/vector_unit_monitor.sv ***
`timescale 1ns/10ps
module vector_unit_monitor (
   input wire logic                          SYS_CLK_I,
   input wire logic                          RSTN_I,
   input wire logic                          BOOT_RESET_FUSE_I,
   input wire logic [vector_pkg::ADDR_W-1:0] BOOT_START_I,
   input vector_pkg::irq_lines_t             IRQ_I,
   input vector_pkg::irq_lines_t             IRQ_EN_I,
   input wire logic                          CTRL_WR_I,
   input wire logic [1:0]                    CTRL_WDATA_I,
   input wire logic                          RESET_FETCH_O,
   input wire logic [vector_pkg::ADDR_W-1:0] RESET_ADDR_O,
   input wire logic                          FETCH_VALID_O,
   input wire logic [vector_pkg::ADDR_W-1:0] FETCH_ADDR_O,
   input wire logic [vector_pkg::SRC_N-1:0]  FETCH_ACK_O,
   input wire logic                          VECTOR_BASE_SELECT_O,
   input wire logic                          VECTOR_CHANGE_UNLOCK_O,
   input wire logic                          DISPATCH_BLOCKED_O
);
   import vector_pkg::*;
   logic [SRC_N-1:0]  pend;
   logic [ADDR_W-1:0] idx;
   logic [ADDR_W-1:0] base;

   assign pend = IRQ_I & IRQ_EN_I;
   assign base = VECTOR_BASE_SELECT_O ? BOOT_START_I : 12'h000;
   always_comb begin
      idx = 12'h000;
      for (int i = 0; i < SRC_N; i++) if (FETCH_ACK_O[i]) idx = ADDR_W'(i);
   end

   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!RSTN_I);

   one_source_a:
      assert property (FETCH_VALID_O |-> $onehot(FETCH_ACK_O)) else $error("ack not one-hot");
   vec_addr_a:
      assert property (FETCH_VALID_O |-> FETCH_ADDR_O == base + idx + 12'h001)
      else $error("vector address wrong");
   lowest_first_a:
      assert property (FETCH_VALID_O |-> ($past(pend) & (FETCH_ACK_O - 16'h0001)) == 16'h0000
         && ($past(pend) & FETCH_ACK_O) != 16'h0000) else $error("source not lowest pending");
   reset_addr_a:
      assert property (RESET_FETCH_O |-> RESET_ADDR_O == (BOOT_RESET_FUSE_I ? 12'h000
         : BOOT_START_I) ##1 !RESET_FETCH_O) else $error("reset fetch wrong");
   unlock_expire_a:
      assert property ($rose(VECTOR_CHANGE_UNLOCK_O) |-> ##[1:4] !VECTOR_CHANGE_UNLOCK_O)
      else $error("unlock stays too long");
   unlock_hold_a:
      assert property ($rose(VECTOR_CHANGE_UNLOCK_O) ##0 !CTRL_WR_I [*3] |=>
         VECTOR_CHANGE_UNLOCK_O) else $error("unlock cleared early");
   select_load_a:
      assert property (VECTOR_CHANGE_UNLOCK_O && CTRL_WR_I && !CTRL_WDATA_I[0] |=>
         VECTOR_BASE_SELECT_O == $past(CTRL_WDATA_I[1]) && !VECTOR_CHANGE_UNLOCK_O)
      else $error("select write not taken");
   select_guard_a:
      assert property (!VECTOR_CHANGE_UNLOCK_O |=> $stable(VECTOR_BASE_SELECT_O))
      else $error("select changed while locked");
   blocked_quiet_a:
      assert property (DISPATCH_BLOCKED_O |-> !FETCH_VALID_O) else $error("fetch while blocked");

   cover property (FETCH_VALID_O && VECTOR_BASE_SELECT_O);
   cover property ($fell(VECTOR_CHANGE_UNLOCK_O) && !VECTOR_BASE_SELECT_O);
   cover property (RESET_FETCH_O && RESET_ADDR_O != 12'h000);
endmodule : vector_unit_monitor

bind vector_unit vector_unit_monitor u_monitor (
   .SYS_CLK_I              (SYS_CLK_I),
   .RSTN_I                 (RSTN_I),
   .BOOT_RESET_FUSE_I      (BOOT_RESET_FUSE_I),
   .BOOT_START_I           (BOOT_START_I),
   .IRQ_I                  (IRQ_I),
   .IRQ_EN_I               (IRQ_EN_I),
   .CTRL_WR_I              (CTRL_WR_I),
   .CTRL_WDATA_I           (CTRL_WDATA_I),
   .RESET_FETCH_O          (RESET_FETCH_O),
   .RESET_ADDR_O           (RESET_ADDR_O),
   .FETCH_VALID_O          (FETCH_VALID_O),
   .FETCH_ADDR_O           (FETCH_ADDR_O),
   .FETCH_ACK_O            (FETCH_ACK_O),
   .VECTOR_BASE_SELECT_O   (VECTOR_BASE_SELECT_O),
   .VECTOR_CHANGE_UNLOCK_O (VECTOR_CHANGE_UNLOCK_O),
   .DISPATCH_BLOCKED_O     (DISPATCH_BLOCKED_O)
);

// *** bench/reset_interrupt_vector_placement_bench.sv ***
`timescale 1ns/10ps
module reset_interrupt_vector_placement_bench;
   import vector_pkg::*;
   localparam logic [ADDR_W-1:0] BOOT = 12'hC00;
   logic              SYS_CLK_I, RSTN_I, BOOT_RESET_FUSE_I, GLOBAL_IE_I, TAKE_OK_I, run, slow;
   logic              INSTR_DONE_I, CTRL_WR_I, RESET_FETCH_O, FETCH_VALID_O;
   logic              VECTOR_BASE_SELECT_O, VECTOR_CHANGE_UNLOCK_O, DISPATCH_BLOCKED_O;
   logic [1:0]        CTRL_WDATA_I;
   logic [ADDR_W-1:0] BOOT_START_I, RESET_ADDR_O, FETCH_ADDR_O, base;
   logic [SRC_N-1:0]  FETCH_ACK_O;
   irq_lines_t        IRQ_I, IRQ_EN_I;
   int                n_errors, n_tests, nu, nf, nl, nb;

   vector_unit u_dut (
      .SYS_CLK_I              (SYS_CLK_I),
      .RSTN_I                 (RSTN_I),
      .BOOT_RESET_FUSE_I      (BOOT_RESET_FUSE_I),
      .BOOT_START_I           (BOOT_START_I),
      .IRQ_I                  (IRQ_I),
      .IRQ_EN_I               (IRQ_EN_I),
      .GLOBAL_IE_I            (GLOBAL_IE_I),
      .TAKE_OK_I              (TAKE_OK_I),
      .INSTR_DONE_I           (INSTR_DONE_I),
      .CTRL_WR_I              (CTRL_WR_I),
      .CTRL_WDATA_I           (CTRL_WDATA_I),
      .RESET_FETCH_O          (RESET_FETCH_O),
      .RESET_ADDR_O           (RESET_ADDR_O),
      .FETCH_VALID_O          (FETCH_VALID_O),
      .FETCH_ADDR_O           (FETCH_ADDR_O),
      .FETCH_ACK_O            (FETCH_ACK_O),
      .VECTOR_BASE_SELECT_O   (VECTOR_BASE_SELECT_O),
      .VECTOR_CHANGE_UNLOCK_O (VECTOR_CHANGE_UNLOCK_O),
      .DISPATCH_BLOCKED_O     (DISPATCH_BLOCKED_O)
   );
   core_model u_core (.clk_i(SYS_CLK_I), .rstn_i(RSTN_I), .slow_i(slow), .run_i(run),
      .fetch_i(FETCH_VALID_O), .take_ok_o(TAKE_OK_I), .done_o(INSTR_DONE_I));

   initial begin
      SYS_CLK_I = 1'b0;
      forever #2.5 SYS_CLK_I = ~SYS_CLK_I;
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : test_done

   task automatic hang(input string what);
      chk(what, 16'h0001, 16'h0000);
      test_done();
   endtask : hang

   task automatic ctrl(input logic [1:0] d);
      @(posedge SYS_CLK_I);
      CTRL_WR_I    <= 1'b1;
      CTRL_WDATA_I <= d;
      @(posedge SYS_CLK_I);
      CTRL_WR_I <= 1'b0;
   endtask : ctrl

   task automatic t_reset(input logic fuse);
      @(posedge SYS_CLK_I);
      RSTN_I            <= 1'b0;
      BOOT_RESET_FUSE_I <= fuse;
      repeat (6) @(posedge SYS_CLK_I);
      RSTN_I <= 1'b1;
      for (int n = 0; n < 20 && RESET_FETCH_O !== 1'b1; n++) @(negedge SYS_CLK_I);
      if (RESET_FETCH_O !== 1'b1) hang("reset fetch");
      chk("reset addr", fuse ? 16'h0000 : 16'(BOOT), 16'(RESET_ADDR_O));
      chk("select", 16'h0000, 16'(VECTOR_BASE_SELECT_O));
      $display("reset test done");
   endtask : t_reset

   // Idx below zero means no fetch may appear
   task automatic dispatch(input logic [15:0] req, input logic [15:0] en, input int idx);
      @(posedge SYS_CLK_I);
      IRQ_I    <= irq_lines_t'(req);
      IRQ_EN_I <= irq_lines_t'(en);
      for (int n = 0; n < 12 && FETCH_VALID_O !== 1'b1; n++) @(negedge SYS_CLK_I);
      if (idx < 0) chk("no fetch", 16'h0000, 16'(FETCH_VALID_O));
      else if (FETCH_VALID_O !== 1'b1) hang("fetch");
      else begin
         chk("vector", 16'(base + idx + 1), 16'(FETCH_ADDR_O));
         chk("source", 16'(16'h0001 << idx), FETCH_ACK_O);
      end
      @(posedge SYS_CLK_I);
      IRQ_I <= '0;
      $display("dispatch test done");
   endtask : dispatch

   task automatic t_expire;
      nu = 0;
      nf = 0;
      nl = 0;
      nb = 0;
      @(posedge SYS_CLK_I);
      CTRL_WR_I    <= 1'b1;
      CTRL_WDATA_I <= 2'h1;
      IRQ_I        <= irq_lines_t'(16'h0010);
      @(posedge SYS_CLK_I);
      CTRL_WR_I <= 1'b0;
      repeat (10) begin
         @(negedge SYS_CLK_I);
         nu += int'(VECTOR_CHANGE_UNLOCK_O === 1'b1);
         nf += int'(FETCH_VALID_O === 1'b1 && VECTOR_CHANGE_UNLOCK_O === 1'b1);
         nl += int'(FETCH_VALID_O === 1'b1 && VECTOR_CHANGE_UNLOCK_O === 1'b0);
         nb += int'(DISPATCH_BLOCKED_O === 1'b1);
      end
      chk("unlock cycles", 16'(UNLOCK_CYCLES), 16'(nu));
      chk("blocked cycles", 16'(UNLOCK_CYCLES), 16'(nb));
      chk("blocked fetch", 16'h0000, 16'(nf));
      chk("later fetch", 16'h0001, 16'(nl != 0));
      @(posedge SYS_CLK_I);
      IRQ_I <= '0;
      $display("expire test done");
   endtask : t_expire

   task automatic t_select;
      @(posedge SYS_CLK_I);
      run <= 1'b0;
      ctrl(2'h1);
      ctrl(2'h2);
      @(negedge SYS_CLK_I);
      chk("select", 16'h0001, 16'(VECTOR_BASE_SELECT_O));
      chk("unlock", 16'h0000, 16'(VECTOR_CHANGE_UNLOCK_O));
      chk("blocked", 16'h0001, 16'(DISPATCH_BLOCKED_O));
      dispatch(16'h0001, 16'hFFFF, -1);
      run  <= 1'b1;
      base = BOOT;
      dispatch(16'h8000, 16'hFFFF, 15);
      ctrl(2'h0);
      @(negedge SYS_CLK_I);
      chk("locked select", 16'h0001, 16'(VECTOR_BASE_SELECT_O));
      ctrl(2'h1);
      ctrl(2'h0);
      @(negedge SYS_CLK_I);
      chk("select back", 16'h0000, 16'(VECTOR_BASE_SELECT_O));
      base = 12'h000;
      $display("select test done");
   endtask : t_select

   initial begin
      RSTN_I            = 1'b0;
      BOOT_RESET_FUSE_I = 1'b0;
      BOOT_START_I      = BOOT;
      GLOBAL_IE_I       = 1'b1;
      CTRL_WR_I         = 1'b0;
      CTRL_WDATA_I      = 2'h0;
      IRQ_I             = '0;
      IRQ_EN_I          = '0;
      {run, slow}       = 2'h2;
      base              = 12'h000;
      {n_errors, n_tests} = '0;
      t_reset(1'b0);
      for (int i = 0; i < SRC_N; i++) dispatch(16'(16'h0001 << i), 16'hFFFF, i);
      dispatch(16'hFFFF, 16'h0000, -1);
      GLOBAL_IE_I <= 1'b0;
      dispatch(16'hFFFF, 16'hFFFF, -1);
      GLOBAL_IE_I <= 1'b1;
      slow        <= 1'b1;
      dispatch(16'hA0A0, 16'hFFFF, 5);
      dispatch(16'hFFFF, 16'hFFF0, 4);
      slow <= 1'b0;
      t_expire();
      t_select();
      t_reset(1'b1);
      test_done();
   end
endmodule : reset_interrupt_vector_placement_bench
